// [core/ldss_map.vh]
// Constants for the load and heat-demand source selector.
`ifndef LDSS_MAP_VH
`define LDSS_MAP_VH
// Demand source mode codes.
`define LDSS_MODE_EXT_CONTACT   3'h0
`define LDSS_MODE_INTERNAL      3'h1
`define LDSS_MODE_INT_BUS_SP    3'h2
`define LDSS_MODE_INT_ANALOG_SP 3'h3
`define LDSS_MODE_EXT_ANALOG    3'h4
`define LDSS_MODE_EXT_BUS       3'h5
// Control characteristic codes.
`define LDSS_CHAR_TWO_STAGE     2'h0
`define LDSS_CHAR_THREE_STAGE   2'h1
`define LDSS_CHAR_MODULATING    2'h2
// Register offsets.
`define LDSS_REG_MODE           4'h0
`define LDSS_REG_CHAR           4'h1
`define LDSS_REG_SP1            4'h2
`define LDSS_REG_SP2            4'h3
`define LDSS_REG_MOD_ON         4'h4
`define LDSS_REG_MOD_OFF        4'h5
`define LDSS_REG_ST1_ON         4'h6
`define LDSS_REG_ST1_OFF        4'h7
`define LDSS_REG_BUS_SP         4'h8
`define LDSS_REG_BUS_LOAD       4'h9
`define LDSS_REG_STATUS         4'hA
`define LDSS_REG_ACTUAL         4'hB
// Control register field positions.
`define LDSS_CTL_INPUT_EN_BIT   3
`define LDSS_CTL_LIMITER_BIT    4
`define LDSS_CTL_BUS_DEMAND_BIT 5
// Reset values.
`define LDSS_RST_MODE           3'h1
`define LDSS_RST_CHAR           2'h2
`endif

// [core/ldss_hyst.v]
// Two-position heat-demand controller with switching-differential hysteresis.
`timescale 1ns/1ps
module ldss_hyst #(
  parameter W = 16
) (
  input  wire                 clk_in,      // System clock.
  input  wire                 rstn_in,     // Asynchronous reset, active low.
  input  wire                 ce_in,       // Clock enable.
  input  wire                 run_in,      // Controller active.
  input  wire signed [W-1:0]  actual_in,   // Actual value.
  input  wire signed [W-1:0]  setpoint_in, // Active setpoint.
  input  wire signed [W-1:0]  on_off_in,   // Signed switch-on offset.
  input  wire signed [W-1:0]  off_off_in,  // Switch-off offset.
  output reg                  demand_out   // Heat-demand flag.
);
  // One extra bit keeps the threshold sums from wrapping.
  wire signed [W:0] on_thr  = {setpoint_in[W-1], setpoint_in} + {on_off_in[W-1], on_off_in};
  wire signed [W:0] off_thr = {setpoint_in[W-1], setpoint_in} + {off_off_in[W-1], off_off_in};
  wire signed [W:0] act_x   = {actual_in[W-1], actual_in};

  // Off has priority if thresholds overlap; between them the flag holds.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      demand_out <= 1'b0;
    end else if (ce_in) begin
      if (!run_in)
        demand_out <= 1'b0;
      else if (act_x > off_thr)
        demand_out <= 1'b0;
      else if (act_x <= on_thr)
        demand_out <= 1'b1;
      else
        demand_out <= demand_out;
    end
  end
endmodule

// [core/ldss_top.v]
// Load and heat-demand source selector with internal two-position controller.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ldss_map.vh"

// This block decides where heat demand and load come from and keeps the
// on/off flag; the PID algorithm, adaption and actuator control sit elsewhere.
// Analog values arrive already converted and registered on this clock.
// The CAN message is framed downstream; can_load_vld_out only marks the load as valid.
// A bouncing contact may flip the source for a cycle; debouncing is left to the wiring.
// Mode codes, field positions and reset values live in the map header.

module ldss_top #(
  parameter W = 16
) (
  // Clock, reset and enable.
  input  wire         clk_in,          // System clock, 25 MHz.
  input  wire         rstn_in,         // Asynchronous reset, active low.
  input  wire         ce_in,           // Clock enable, freezes all state.

  // Register bus, read data one cycle after the strobe.
  input  wire [3:0]   addr_in,         // Register address.
  input  wire [15:0]  wdata_in,        // Register write data.
  input  wire         wr_in,           // Write strobe.
  input  wire         rd_in,           // Read strobe.
  output reg  [15:0]  rdata_out,       // Read data, one cycle after strobe.

  // Contact pins, synchronised inside.
  input  wire         changeover_in,   // Changeover contact pin, high closed.
  input  wire [2:0]   ext_contacts_in, // External controller contacts pins.
  input  wire         sp_select_in,    // Second setpoint contact pin.

  // Values on this clock, taken without synchronising.
  input  wire [W-1:0] actual_in,       // Actual value, same clock.
  input  wire [W-1:0] analog_sp_in,    // Analog input three setpoint.
  input  wire [W-1:0] analog_load_in,  // External analog load command.

  // Outputs, each straight from a flip-flop.
  output reg  [2:0]   eff_mode_out,    // Effective demand source mode.
  output reg          demand_out,      // Heat demand to sequencer.
  output reg  [W-1:0] load_out,        // Load for burner system.
  output reg          can_load_vld_out,// Load is to be sent as CAN message.
  output reg  [2:0]   stage_cmd_out,   // Contact stage command to sequencer.
  output reg          limiter_en_out,  // Temperature limiter enabled.
  output reg          params_vis_out   // Internal parameters offered.
);

  // Register map, one 16-bit word per address:
  // 0x0 mode in bits 2:0, input enable bit 3, limiter bit 4, bus demand bit 5.
  // 0x1 control characteristic in bits 1:0; code 3 is refused.
  // 0x2 first internal setpoint.
  // 0x3 second internal setpoint.
  // 0x4 modulating switch-on offset, signed.
  // 0x5 modulating switch-off offset.
  // 0x6 stage one switch-on offset, signed.
  // 0x7 stage one switch-off offset.
  // 0x8 setpoint written by the building automation system.
  // 0x9 load written by the building automation system.
  // 0xA status, read only.
  // 0xB actual value, read only.
  // Writes to 0x2 to 0x7 are dropped while an external mode is stored.

  // Stored configuration, written by the operator unit.
  reg [2:0]   demand_source_mode_q;
  reg [1:0]   char_q;
  reg         input_en_q;
  reg         limiter_q;
  reg         bus_demand_q;

  // Internal controller parameters, locked while an external mode is stored.
  reg [W-1:0] first_internal_setpoint_q;
  reg [W-1:0] second_internal_setpoint_q;
  reg [W-1:0] modulating_on_offset_q;
  reg [W-1:0] modulating_off_offset_q;
  reg [W-1:0] stage_one_on_offset_q;
  reg [W-1:0] stage_one_off_offset_q;

  // Values written by the building automation system.
  reg [W-1:0] bus_sp_q;
  reg [W-1:0] bus_load_q;

  // Two-flop synchronisers for the pin inputs.
  reg [4:0]   sync1_q;
  reg [4:0]   sync2_q;
  // Bit 0 is the changeover contact, bit 1 setpoint select, bits 4:2 the contacts.
  // Only sync2_q reads sync1_q; all logic reads the second stage.
  wire        chg_s   = sync2_q[0];
  wire        spsel_s = sync2_q[1];
  wire [2:0]  cont_s  = sync2_q[4:2];

  // Next effective mode, decoded without a register, and registered contact state.
  reg [2:0]   mode_d;
  reg         forced_q;

  // True for the modes in which an outside controller owns the demand.
  // Used for the parameter lock and for the visibility flag alike.
  function is_external;
    input [2:0] m;
    begin
      is_external = (m == `LDSS_MODE_EXT_CONTACT) || (m == `LDSS_MODE_EXT_ANALOG) ||
                    (m == `LDSS_MODE_EXT_BUS);
    end
  endfunction

  // Pins pass two flops before any logic sees them.
  // A pin edge reaches the effective mode three edges later and the
  // heat-demand flag one or two edges after that; the extra latency is the
  // price of never feeding a metastable level into the mode decode.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else if (ce_in) begin
      sync1_q <= {ext_contacts_in, sp_select_in, changeover_in};
      sync2_q <= sync1_q;
    end
  end

  // Register writes; the contact changeover never touches the stored mode.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Reset selects the internal controller and modulating operation.
      demand_source_mode_q       <= `LDSS_RST_MODE;
      char_q                     <= `LDSS_RST_CHAR;
      input_en_q                 <= 1'b0;
      limiter_q                  <= 1'b0;
      bus_demand_q               <= 1'b0;
      first_internal_setpoint_q  <= {W{1'b0}};
      second_internal_setpoint_q <= {W{1'b0}};
      modulating_on_offset_q     <= {W{1'b0}};
      modulating_off_offset_q    <= {W{1'b0}};
      stage_one_on_offset_q      <= {W{1'b0}};
      stage_one_off_offset_q     <= {W{1'b0}};
      bus_sp_q                   <= {W{1'b0}};
      bus_load_q                 <= {W{1'b0}};
    end else if (ce_in && wr_in) begin
      case (addr_in)
        `LDSS_REG_MODE: begin
          // Control bits are taken even when the mode code is refused.
          if (wdata_in[2:0] <= `LDSS_MODE_EXT_BUS)
            demand_source_mode_q <= wdata_in[2:0];
          input_en_q   <= wdata_in[`LDSS_CTL_INPUT_EN_BIT];
          limiter_q    <= wdata_in[`LDSS_CTL_LIMITER_BIT];
          bus_demand_q <= wdata_in[`LDSS_CTL_BUS_DEMAND_BIT];
        end
        `LDSS_REG_CHAR: begin
          // Code 3 has no meaning and would fall to the stage one offsets.
          if (wdata_in[1:0] != 2'h3)
            char_q <= wdata_in[1:0];
        end
        // Bus values stay writable in every mode, as the bus owns them.
        `LDSS_REG_BUS_SP:   bus_sp_q   <= wdata_in[W-1:0];
        `LDSS_REG_BUS_LOAD: bus_load_q <= wdata_in[W-1:0];
        default: begin
          // Internal controller parameters locked while an external mode is stored.
          if (!is_external(demand_source_mode_q)) begin
            case (addr_in)
              `LDSS_REG_SP1:     first_internal_setpoint_q  <= wdata_in[W-1:0];
              `LDSS_REG_SP2:     second_internal_setpoint_q <= wdata_in[W-1:0];
              `LDSS_REG_MOD_ON:  modulating_on_offset_q     <= wdata_in[W-1:0];
              `LDSS_REG_MOD_OFF: modulating_off_offset_q    <= wdata_in[W-1:0];
              `LDSS_REG_ST1_ON:  stage_one_on_offset_q      <= wdata_in[W-1:0];
              `LDSS_REG_ST1_OFF: stage_one_off_offset_q     <= wdata_in[W-1:0];
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  // Effective mode: a closed contact overrides any stored mode.
  // The stored mode is left alone, so opening the contact restores it at once.
  always @* begin
    if (chg_s)
      mode_d = `LDSS_MODE_INTERNAL;
    else
      mode_d = demand_source_mode_q;
  end

  // One register stage gives every change of source a clean cycle boundary.
  // The forced flag remembers that the internal mode came from the contact.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eff_mode_out <= `LDSS_RST_MODE;
      forced_q     <= 1'b0;
    end else if (ce_in) begin
      eff_mode_out <= mode_d;
      forced_q     <= chg_s;
    end
  end

  // Setpoint and offset selection for the effective mode.
  // The offset pair follows the characteristic: modulating uses its own pair,
  // both multistage characteristics share the stage one pair.
  reg  [W-1:0] sp_sel;
  reg          ctrl_run;
  wire         modulating = (char_q == `LDSS_CHAR_MODULATING);
  wire [W-1:0] on_sel  = modulating ? modulating_on_offset_q  : stage_one_on_offset_q;
  wire [W-1:0] off_sel = modulating ? modulating_off_offset_q : stage_one_off_offset_q;

  always @* begin
    sp_sel   = first_internal_setpoint_q;
    ctrl_run = 1'b0;
    case (eff_mode_out)
      `LDSS_MODE_INTERNAL: begin
        ctrl_run = 1'b1;
        // A forced changeover always uses the first setpoint.
        sp_sel = (spsel_s && !forced_q) ? second_internal_setpoint_q
                                        : first_internal_setpoint_q;
      end
      `LDSS_MODE_INT_BUS_SP: begin
        // Only the setpoint comes over the bus; control stays inside.
        ctrl_run = 1'b1;
        sp_sel   = bus_sp_q;
      end
      `LDSS_MODE_INT_ANALOG_SP: begin
        // As the bus setpoint mode, with the setpoint from analog input three.
        ctrl_run = 1'b1;
        sp_sel   = analog_sp_in;
      end
      default: begin
        // External modes hold the controller off, so it restarts from a clear flag.
        ctrl_run = 1'b0;
        sp_sel   = first_internal_setpoint_q;
      end
    endcase
  end

  // Heat-demand flag from the two-position controller; offsets are signed.
  wire hyst_demand;

  ldss_hyst #(
    .W (W)
  ) u_hyst (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .run_in      (ctrl_run),
    .actual_in   (actual_in),
    .setpoint_in (sp_sel),
    .on_off_in   (on_sel),
    .off_off_in  (off_sel),
    .demand_out  (hyst_demand)
  );

  // The contact input counts in contact mode whatever the enable says.
  // In the internal mode it is never read, so a stale enable cannot inject demand.
  wire contacts_live = (eff_mode_out == `LDSS_MODE_EXT_CONTACT) ||
                       (input_en_q && !forced_q && eff_mode_out != `LDSS_MODE_INTERNAL);

  // Output stage: demand, load and contact command per source.
  // Every output leaves a flip-flop, so the sequencer never sees a decode glitch.
  // Visibility follows the stored mode, not the forced one, as the contact
  // leaves the setting untouched.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      demand_out       <= 1'b0;
      load_out         <= {W{1'b0}};
      can_load_vld_out <= 1'b0;
      stage_cmd_out    <= 3'h0;
      limiter_en_out   <= 1'b0;
      params_vis_out   <= 1'b1;
    end else if (ce_in) begin
      stage_cmd_out  <= contacts_live ? cont_s : 3'h0;
      limiter_en_out <= limiter_q;
      params_vis_out <= !is_external(demand_source_mode_q);
      case (eff_mode_out)
        `LDSS_MODE_EXT_CONTACT: begin
          // Any closed contact asks for heat.
          demand_out       <= |cont_s;
          load_out         <= {W{1'b0}};
          can_load_vld_out <= 1'b0;
        end
        `LDSS_MODE_EXT_ANALOG: begin
          // A nonzero analog load is taken as heat demand.
          demand_out       <= analog_load_in != {W{1'b0}};
          load_out         <= analog_load_in;
          can_load_vld_out <= 1'b1;
        end
        `LDSS_MODE_EXT_BUS: begin
          // Load and demand both come over the bus.
          demand_out       <= bus_demand_q;
          load_out         <= bus_load_q;
          can_load_vld_out <= 1'b0;
        end
        default: begin
          // Internal modes: the two-position controller decides.
          demand_out       <= hyst_demand;
          load_out         <= {W{1'b0}};
          can_load_vld_out <= 1'b0;
        end
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero.
  // Idle cycles return zero so a stale word is never mistaken for fresh data.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 16'h0000;
    end else if (ce_in) begin
      if (rd_in) begin
        case (addr_in)
          `LDSS_REG_MODE:     rdata_out <= {10'h000, bus_demand_q, limiter_q, input_en_q, demand_source_mode_q};
          `LDSS_REG_CHAR:     rdata_out <= {14'h0000, char_q};
          `LDSS_REG_SP1:      rdata_out <= first_internal_setpoint_q;
          `LDSS_REG_SP2:      rdata_out <= second_internal_setpoint_q;
          `LDSS_REG_MOD_ON:   rdata_out <= modulating_on_offset_q;
          `LDSS_REG_MOD_OFF:  rdata_out <= modulating_off_offset_q;
          `LDSS_REG_ST1_ON:   rdata_out <= stage_one_on_offset_q;
          `LDSS_REG_ST1_OFF:  rdata_out <= stage_one_off_offset_q;
          `LDSS_REG_BUS_SP:   rdata_out <= bus_sp_q;
          `LDSS_REG_BUS_LOAD: rdata_out <= bus_load_q;
          // Status packs forced, demand, contacts and effective mode in the low byte.
          `LDSS_REG_STATUS:   rdata_out <= {8'h00, forced_q, demand_out, cont_s, eff_mode_out};
          // The actual value is read live, as the controller compares it.
          `LDSS_REG_ACTUAL:   rdata_out <= actual_in;
          default:            rdata_out <= 16'h0000;
        endcase
      end else begin
        rdata_out <= 16'h0000;
      end
    end
  end
endmodule

// [verif/ldss_sva.sv]
// Port-level assertion checker for the demand source selector.
`timescale 1ns/1ps
module ldss_sva #(
  parameter W = 16
) (
  input wire logic         clk_in,           // System clock.
  input wire logic         rstn_in,          // Reset, active low.
  input wire logic         ce_in,            // Clock enable.
  input wire logic [3:0]   addr_in,          // Register address.
  input wire logic [15:0]  wdata_in,         // Write data.
  input wire logic         wr_in,            // Write strobe.
  input wire logic         rd_in,            // Read strobe.
  input wire logic [15:0]  rdata_out,        // Read data.
  input wire logic         changeover_in,    // Changeover contact.
  input wire logic [2:0]   eff_mode_out,     // Effective mode.
  input wire logic [W-1:0] load_out,         // Load value.
  input wire logic         can_load_vld_out, // Load forwarded flag.
  input wire logic [2:0]   stage_cmd_out,    // Contact stage command.
  input wire logic         limiter_en_out    // Limiter enable.
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // The contact must be open long enough that the synchronizer cannot override a mode write.
  sequence s_open; (!changeover_in && ce_in) [*4]; endsequence
  sequence s_mode_wr; wr_in && ce_in && addr_in == 4'h0 && wdata_in[2:0] < 3'h6; endsequence
  property p_mode_apply; s_open ##0 s_mode_wr |=> ##1 eff_mode_out == $past(wdata_in[2:0], 2); endproperty
  property p_force; (changeover_in && ce_in) [*4] |=> eff_mode_out == 3'h1; endproperty
  property p_range; eff_mode_out <= 3'h5; endproperty
  property p_vld; can_load_vld_out |-> eff_mode_out == 3'h4 || $past(eff_mode_out) == 3'h4; endproperty
  property p_load; load_out != 0 |-> eff_mode_out > 3'h3 || $past(eff_mode_out) > 3'h3; endproperty
  property p_stage; eff_mode_out == 3'h1 && $past(eff_mode_out) == 3'h1 |-> stage_cmd_out == 3'h0; endproperty
  property p_limit; wr_in && ce_in && addr_in == 4'h0 |-> ##2 limiter_en_out == $past(wdata_in[4], 2); endproperty
  property p_rdata; !$past(rd_in) && $past(ce_in) |-> rdata_out == 16'h0000; endproperty
  a_mode_apply: assert property (p_mode_apply) else $error("mode write not applied");
  a_force: assert property (p_force) else $error("changeover did not force internal mode");
  a_range: assert property (p_range) else $error("effective mode out of range");
  a_vld: assert property (p_vld) else $error("load forwarded outside analog load mode");
  a_load: assert property (p_load) else $error("load driven outside external load modes");
  a_stage: assert property (p_stage) else $error("contacts live in internal mode");
  a_limit: assert property (p_limit) else $error("limiter enable not copied");
  a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule
bind ldss_top ldss_sva #(.W(W)) u_ldss_sva (.*);

// [verif/ldss_ext_ctrl.sv]
// Behavioural external load controller driving the contact and analog lines.
`timescale 1ns/1ps
module ldss_ext_ctrl #(
  parameter W = 16
) (
  input  wire logic         clk_in,         // System clock.
  input  wire logic         rstn_in,        // Reset, active low.
  input  wire logic         co_want_in,     // Close the changeover contact.
  input  wire logic [2:0]   cont_want_in,   // Wanted contact pattern.
  input  wire logic         sp2_want_in,    // Wanted second setpoint contact.
  input  wire logic [W-1:0] sp_want_in,     // Wanted analog setpoint.
  input  wire logic [W-1:0] load_want_in,   // Wanted analog load.
  output logic              changeover_out, // Changeover contact.
  output logic [2:0]        contacts_out,   // Three controller contacts.
  output logic              sp2_out,        // Second setpoint contact.
  output logic [W-1:0]      sp_out,         // Analog setpoint line.
  output logic [W-1:0]      load_out        // Analog load line.
);
  // Lines move only on an edge, so a relay card that settles late is not modelled.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      changeover_out <= 1'b0;
      contacts_out   <= 3'h0;
      sp2_out        <= 1'b0;
      sp_out         <= '0;
      load_out       <= '0;
    end else begin
      changeover_out <= co_want_in;
      contacts_out   <= cont_want_in;
      sp2_out        <= sp2_want_in;
      sp_out         <= sp_want_in;
      load_out       <= load_want_in;
    end
  end
endmodule

// [verif/ldss_tb_top.sv]
// Self-checking testbench for the demand source selector.
`timescale 1ns/1ps
module ldss_tb_top;
  logic        clk_in = 1'b0, rstn_in, ce_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000, actual_in = 16'h0000, rdata_out, load_out, analog_sp_in, analog_load_in;
  logic [15:0] sp_want = 16'h0000, load_want = 16'h0000;
  logic [2:0]  ext_contacts_in, eff_mode_out, stage_cmd_out, cont_want = 3'h0;
  logic        changeover_in, sp_select_in, demand_out, can_load_vld_out, limiter_en_out, params_vis_out;
  logic        co_want = 1'b0, sp2_want = 1'b0;
  int          bad_count = 0, checked = 0;
  // Free-running 25 MHz clock.
  initial forever #20 clk_in = ~clk_in;
  ldss_top #(.W(16)) u_ldss_top (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .changeover_in(changeover_in),
    .ext_contacts_in(ext_contacts_in), .sp_select_in(sp_select_in), .actual_in(actual_in),
    .analog_sp_in(analog_sp_in), .analog_load_in(analog_load_in), .eff_mode_out(eff_mode_out),
    .demand_out(demand_out), .load_out(load_out), .can_load_vld_out(can_load_vld_out),
    .stage_cmd_out(stage_cmd_out), .limiter_en_out(limiter_en_out), .params_vis_out(params_vis_out));
  ldss_ext_ctrl #(.W(16)) u_ldss_ext_ctrl (.clk_in(clk_in), .rstn_in(rstn_in), .co_want_in(co_want),
    .cont_want_in(cont_want), .sp2_want_in(sp2_want), .sp_want_in(sp_want), .load_want_in(load_want),
    .changeover_out(changeover_in), .contacts_out(ext_contacts_in), .sp2_out(sp_select_in),
    .sp_out(analog_sp_in), .load_out(analog_load_in));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  // Pins pass the partner flop and a two-stage synchronizer, so allow six edges.
  task automatic pins(input logic co, input logic [2:0] c, input logic s2);
    @(posedge clk_in);
    co_want   <= co;
    cont_want <= c;
    sp2_want  <= s2;
    wt(6);
  endtask
  task automatic hy(input logic [15:0] a, input logic e);
    @(posedge clk_in);
    actual_in <= a;
    wt(4);
    chk(16'(demand_out), 16'(e));
  endtask
  // Main sequence of tests.
  initial begin
    rstn_in = 1'b0;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1 chk(16'(eff_mode_out), 16'h0001);
    chk(16'(params_vis_out), 16'h0001);
    rd(4'h0, 16'h0001);
    rd(4'h1, 16'h0002);
    rd(4'hF, 16'h0000);
    $display("test reset done");
    for (int m = 0; m < 6; m++) begin
      wr(4'h0, 16'(m));
      wt(3);
      chk(16'(eff_mode_out), 16'(m));
      chk(16'(params_vis_out), (m == 0 || m > 3) ? 16'h0000 : 16'h0001);
    end
    wr(4'h0, 16'h0006);
    wt(3);
    chk(16'(eff_mode_out), 16'h0005);
    $display("test modes done");
    // With the enable low a mode write must not land.
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(4'h0, 16'h0001);
    wt(3);
    chk(16'(eff_mode_out), 16'h0005);
    @(posedge clk_in);
    ce_in <= 1'b1;
    wr(4'h0, 16'h0010);
    pins(1'b0, 3'h5, 1'b0);
    chk(16'(stage_cmd_out), 16'h0005);
    chk(16'(demand_out), 16'h0001);
    chk(16'(limiter_en_out), 16'h0001);
    pins(1'b0, 3'h0, 1'b0);
    chk(16'(demand_out), 16'h0000);
    @(posedge clk_in);
    load_want <= 16'h1234;
    wr(4'h0, 16'h0004);
    wt(4);
    chk(load_out, 16'h1234);
    chk(16'(can_load_vld_out), 16'h0001);
    chk(16'(demand_out), 16'h0001);
    wr(4'h0, 16'h0025);
    wr(4'h9, 16'h0400);
    wt(4);
    chk(load_out, 16'h0400);
    chk(16'(demand_out), 16'h0001);
    chk(16'(can_load_vld_out), 16'h0000);
    $display("test external done");
    pins(1'b1, 3'h0, 1'b0);
    chk(16'(eff_mode_out), 16'h0001);
    rd(4'h0, 16'h0025);
    chk(16'(params_vis_out), 16'h0000);
    pins(1'b0, 3'h0, 1'b0);
    chk(16'(eff_mode_out), 16'h0005);
    wr(4'h0, 16'h000A);
    pins(1'b0, 3'h3, 1'b0);
    chk(16'(stage_cmd_out), 16'h0003);
    pins(1'b1, 3'h3, 1'b0);
    chk(16'(stage_cmd_out), 16'h0000);
    pins(1'b0, 3'h3, 1'b0);
    wr(4'h0, 16'h0002);
    wt(3);
    chk(16'(stage_cmd_out), 16'h0000);
    $display("test changeover done");
    pins(1'b0, 3'h0, 1'b0);
    wr(4'h0, 16'h0001);
    wr(4'h1, 16'h0002);
    wr(4'h2, 16'h0064);
    wr(4'h4, 16'hFFFB);
    wr(4'h5, 16'h000A);
    hy(16'h005F, 1'b1);
    hy(16'h006E, 1'b1);
    hy(16'h006F, 1'b0);
    hy(16'h0060, 1'b0);
    hy(16'h005F, 1'b1);
    wr(4'h1, 16'h0000);
    wr(4'h6, 16'h0005);
    wr(4'h7, 16'h0014);
    hy(16'h0069, 1'b1);
    hy(16'h0078, 1'b1);
    hy(16'h0079, 1'b0);
    hy(16'h006A, 1'b0);
    hy(16'h0069, 1'b1);
    wr(4'h1, 16'h0001);
    hy(16'h0079, 1'b0);
    wr(4'h1, 16'h0002);
    wr(4'h3, 16'h00C8);
    pins(1'b0, 3'h0, 1'b1);
    hy(16'h0096, 1'b1);
    pins(1'b0, 3'h0, 1'b0);
    hy(16'h0096, 1'b0);
    wr(4'h8, 16'h012C);
    wr(4'h0, 16'h0002);
    hy(16'h00FA, 1'b1);
    hy(16'h0190, 1'b0);
    @(posedge clk_in);
    sp_want <= 16'h0032;
    wr(4'h0, 16'h0003);
    hy(16'h0046, 1'b0);
    hy(16'h0028, 1'b1);
    $display("test hysteresis done");
    close_out();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    close_out();
  end
endmodule
